//--- common/adc_ctrl_regs.vh
// register offsets, field positions and constants for the adc control block
// assumes a word-addressed avalon-mm slave, one 32-bit word per register
`ifndef ADC_CTRL_REGS_VH
`define ADC_CTRL_REGS_VH

// printed offsets are not all multiples of four: they are indices, byte address = 4 * index
`define IDX_IRQ_FLAG 8'hC4
`define IDX_IRQ_MASK 8'hC8
`define IDX_REF_GND 8'hF0
`define IDX_RES_SEL 8'hF3
`define IDX_MEAS_TYPE 8'hF4
`define IDX_IN_EN_LO 8'hF5
`define IDX_RUN_IN4 8'hF6
`define IDX_RES_N0 8'hF7
`define IDX_RES_N1 8'hF8
`define IDX_RES_N2 8'hF9
`define IDX_RES_TOP 8'hFA
`define IDX_VALIDITY 8'hFB

// field positions
`define BIT_REF_EN 0
`define BIT_TRIM_EN 1
`define BIT_MID_LO 2
`define BIT_MID_HI 3
`define BIT_IN4_EN 0
`define BIT_RUN 3
`define BIT_IRQ_MASK 2
`define BIT_POLARITY 1

`define NIB_ZERO 4'h0
`define COUNT_W 13
`define COUNT_ZERO 13'h0000
`define RES_ZERO 2'h0
`define IN_EN_ZERO 5'h00
`define PAGE_ZERO 2'h0

// bus field positions
`define BE_NIB 0
`define ADDR_IDX_HI 7
`define ADDR_IDX_LO 0
`define ADDR_PAGE_HI 9
`define ADDR_PAGE_LO 8

// register field positions
`define BIT_RES_LO 0
`define BIT_RES_HI 1
`define NIB_LO 0
`define NIB_HI 3
`define IN_LO_LO 0
`define IN_LO_HI 3
`define IN4_POS 4

// result nibble positions in the count
`define N0_LO 0
`define N0_HI 3
`define N1_LO 4
`define N1_HI 7
`define N2_LO 8
`define N2_HI 11
`define TOP_POS 12

// result read-order tracker states
`define RD_IDLE 3'h0
`define RD_N0 3'h1
`define RD_N1 3'h2
`define RD_N2 3'h3
`define RD_DONE 3'h4

// resolution counts and conversion times (ms x 10)
`define RES_COUNT_0 13'h1998
`define RES_COUNT_1 13'h0CCC
`define RES_COUNT_2 13'h0666
`define RES_COUNT_3 13'h0334
`define CONV_TIME_0 5000
`define CONV_TIME_1 2500
`define CONV_TIME_2 1250
`define CONV_TIME_3 625

`endif

//--- rtl/adc_ctrl.v
// control and result register block for a dual-slope adc
// assumes the analog integrator reports end of reverse integration as a
// one-cycle pulse with its count and polarity, synchronous to sys_clk
// registers are reached by word index; each access takes two cycles
// side effects of a read happen at the edge that takes it
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`include "adc_ctrl_regs.vh"

module adc_ctrl #(
  parameter COUNT_W = `COUNT_W
) (
  input wire sys_clk, // system clock, 125 mhz
  input wire rst_n, // asynchronous reset, active low
  input wire [9:0] avs_address, // word address (index)
  input wire avs_read, // read request
  input wire avs_write, // write request
  input wire [31:0] avs_writedata, // write data
  input wire [3:0] avs_byteenable, // byte enables
  output reg [31:0] avs_readdata, // read data, registered
  output wire avs_waitrequest, // stall
  input wire conv_done, // end of reverse integration pulse
  input wire [COUNT_W-1:0] conv_count, // count at end of reverse integration
  input wire conv_positive, // input polarity at end of conversion
  output reg [1:0] mid_potential_sel, // mid-potential generator mode
  output reg reference_gen_enable, // reference generator on
  output reg reference_trim_enable, // reference trim on
  output reg [1:0] resolution_sel, // resolution select
  output reg [3:0] meas_type, // measurement type bits
  output reg [4:0] analog_in_enable, // analog input connects
  output reg converter_run, // converter powered
  output reg conv_restart, // restart pulse: clear counter, auto-zero
  output wire conv_irq // interrupt request
);

  // one-hot positions of the register select
  localparam SEL_IRQ_FLAG = 0;
  localparam SEL_IRQ_MASK = 1;
  localparam SEL_REF_GND = 2;
  localparam SEL_RES_SEL = 3;
  localparam SEL_MEAS_TYPE = 4;
  localparam SEL_IN_EN_LO = 5;
  localparam SEL_RUN_IN4 = 6;
  localparam SEL_RES_N0 = 7;
  localparam SEL_RES_N1 = 8;
  localparam SEL_RES_N2 = 9;
  localparam SEL_RES_TOP = 10;
  localparam SEL_VALIDITY = 11;
  localparam SEL_W = 12;

  // bus handshake state
  reg ack_r;
  // interrupt and status state
  wire conversion_done_flag_r;
  reg conversion_irq_mask_r;
  wire read_invalid_status_r;
  // result latch
  reg input_polarity_r;
  reg [COUNT_W-1:0] count_result_r;
  // ordered read tracker
  reg [2:0] rd_state_r;
  reg [2:0] rd_state_nxt;
  // read mux output and register select
  reg [3:0] rd_nib;
  reg [SEL_W-1:0] reg_sel;

  // access decode: a request is taken once, in its first cycle
  wire req = (avs_read | avs_write) & ~ack_r;
  wire wr = avs_write & req & avs_byteenable[`BE_NIB];
  wire rd = avs_read & req;
  wire [7:0] idx = avs_address[`ADDR_IDX_HI:`ADDR_IDX_LO];
  wire hit_hi = (avs_address[`ADDR_PAGE_HI:`ADDR_PAGE_LO] == `PAGE_ZERO);

  // register select: one hot, empty outside the mapped page
  always @* begin
    reg_sel = {SEL_W{1'b0}};
    if (hit_hi) begin
      case (idx)
        `IDX_IRQ_FLAG: reg_sel[SEL_IRQ_FLAG] = 1'b1;
        `IDX_IRQ_MASK: reg_sel[SEL_IRQ_MASK] = 1'b1;
        `IDX_REF_GND: reg_sel[SEL_REF_GND] = 1'b1;
        `IDX_RES_SEL: reg_sel[SEL_RES_SEL] = 1'b1;
        `IDX_MEAS_TYPE: reg_sel[SEL_MEAS_TYPE] = 1'b1;
        `IDX_IN_EN_LO: reg_sel[SEL_IN_EN_LO] = 1'b1;
        `IDX_RUN_IN4: reg_sel[SEL_RUN_IN4] = 1'b1;
        `IDX_RES_N0: reg_sel[SEL_RES_N0] = 1'b1;
        `IDX_RES_N1: reg_sel[SEL_RES_N1] = 1'b1;
        `IDX_RES_N2: reg_sel[SEL_RES_N2] = 1'b1;
        `IDX_RES_TOP: reg_sel[SEL_RES_TOP] = 1'b1;
        `IDX_VALIDITY: reg_sel[SEL_VALIDITY] = 1'b1;
        default: reg_sel = {SEL_W{1'b0}};
      endcase
    end
  end

  // write strobes for the converter controls
  wire wr_ref_gnd = wr & reg_sel[SEL_REF_GND]; // references and ground
  wire wr_res_sel = wr & reg_sel[SEL_RES_SEL]; // resolution
  wire wr_meas_type = wr & reg_sel[SEL_MEAS_TYPE]; // measurement type
  wire wr_in_en_lo = wr & reg_sel[SEL_IN_EN_LO]; // inputs 0 to 3

  // write strobes for run and mask
  wire wr_run_in4 = wr & reg_sel[SEL_RUN_IN4]; // run and input 4
  wire wr_irq_mask = wr & reg_sel[SEL_IRQ_MASK]; // interrupt mask

  // reads that clear a status bit
  wire rd_irq_flag = rd & reg_sel[SEL_IRQ_FLAG]; // clears the flag
  wire rd_validity = rd & reg_sel[SEL_VALIDITY]; // clears validity

  // reads that walk the result in order
  wire rd_res_n0 = rd & reg_sel[SEL_RES_N0]; // opens a read sequence
  wire rd_res_n1 = rd & reg_sel[SEL_RES_N1]; // second nibble
  wire rd_res_n2 = rd & reg_sel[SEL_RES_N2]; // third nibble
  wire rd_res_top = rd & reg_sel[SEL_RES_TOP]; // top bit and polarity

  // a stopped converter cannot finish, so its pulses are ignored
  wire latch_now = conv_done & converter_run;

  // readback of every register; unused bits read as zero
  // flag readback
  wire [3:0] rb_irq_flag = {3'h0, conversion_done_flag_r};
  wire [3:0] rb_irq_mask = {1'b0, conversion_irq_mask_r, 2'h0};
  wire [3:0] rb_ref_gnd = {mid_potential_sel, reference_trim_enable, reference_gen_enable};
  wire [3:0] rb_res_sel = {2'h0, resolution_sel};
  wire [3:0] rb_meas_type = meas_type;
  wire [3:0] rb_in_en_lo = analog_in_enable[`IN_LO_HI:`IN_LO_LO];
  wire [3:0] rb_run_in4 = {converter_run, 2'h0, analog_in_enable[`IN4_POS]};
  wire [3:0] rb_res_n0 = count_result_r[`N0_HI:`N0_LO];
  wire [3:0] rb_res_n1 = count_result_r[`N1_HI:`N1_LO];
  wire [3:0] rb_res_n2 = count_result_r[`N2_HI:`N2_LO];
  wire [3:0] rb_res_top = {2'h0, input_polarity_r, count_result_r[`TOP_POS]};
  wire [3:0] rb_validity = {3'h0, read_invalid_status_r};

  // one wait cycle per access so read data comes from a flop
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;

  // ack marks the second cycle of an access
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req;
    end
  end

  // reference and mid-potential controls
  // reset clears all
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mid_potential_sel <= `RES_ZERO;
      reference_gen_enable <= 1'b0;
      reference_trim_enable <= 1'b0;
    end else if (wr_ref_gnd) begin
      mid_potential_sel <= avs_writedata[`BIT_MID_HI:`BIT_MID_LO];
      reference_gen_enable <= avs_writedata[`BIT_REF_EN];
      reference_trim_enable <= avs_writedata[`BIT_TRIM_EN];
    end
  end

  // resolution code only; span and time belong to the analog sequencer
  // resolution select
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      resolution_sel <= `RES_ZERO;
    end else if (wr_res_sel) begin
      resolution_sel <= avs_writedata[`BIT_RES_HI:`BIT_RES_LO];
    end
  end

  // type bits pass through as written; legality is up to software
  // type bits
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meas_type <= `NIB_ZERO;
    end else if (wr_meas_type) begin
      meas_type <= avs_writedata[`NIB_HI:`NIB_LO];
    end
  end

  // analog input connects, split over two registers
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      analog_in_enable <= `IN_EN_ZERO;
    end else begin
      if (wr_in_en_lo) begin
        analog_in_enable[`IN_LO_HI:`IN_LO_LO] <= avs_writedata[`IN_LO_HI:`IN_LO_LO];
      end
      if (wr_run_in4) begin
        analog_in_enable[`IN4_POS] <= avs_writedata[`BIT_IN4_EN];
      end
    end
  end

  // converter power and restart pulse
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      converter_run <= 1'b0;
      conv_restart <= 1'b0;
    end else begin
      // restart lasts one cycle unless written again
      conv_restart <= 1'b0;
      if (wr_run_in4) begin
        converter_run <= avs_writedata[`BIT_RUN];
        // restart from auto-zero on every write of 1
        conv_restart <= avs_writedata[`BIT_RUN];
      end
    end
  end

  // mask for the converter interrupt; other mask bits live elsewhere
  // mask bit
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      conversion_irq_mask_r <= 1'b0;
    end else if (wr_irq_mask) begin
      conversion_irq_mask_r <= avs_writedata[`BIT_IRQ_MASK];
    end
  end

  // result latch, taken only while running; a stopped converter cannot finish
  // latch count
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_result_r <= `COUNT_ZERO;
      input_polarity_r <= 1'b0;
    end else if (latch_now) begin
      count_result_r <= conv_count;
      input_polarity_r <= conv_positive;
    end
  end

  // ordered read tracker: each nibble in turn advances, one out of order restarts
  // progress of the ordered read
  always @* begin
    rd_state_nxt = rd_state_r;
    if (rd_res_n0) begin
      rd_state_nxt = `RD_N0;
    end else if (rd_res_n1) begin
      rd_state_nxt = (rd_state_r == `RD_N0) ? `RD_N1 : `RD_IDLE;
    end else if (rd_res_n2) begin
      rd_state_nxt = (rd_state_r == `RD_N1) ? `RD_N2 : `RD_IDLE;
    end else if (rd_res_top) begin
      rd_state_nxt = (rd_state_r == `RD_N2) ? `RD_DONE : `RD_IDLE;
    end
    // a fresh latch starts a new read sequence
    if (latch_now) begin
      rd_state_nxt = `RD_IDLE;
    end
  end

  // tracker state
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_state_r <= `RD_IDLE;
    end else begin
      rd_state_r <= rd_state_nxt;
    end
  end

  // a read sequence is open from the first nibble until the top nibble
  wire seq_open = (rd_state_r != `RD_IDLE) & (rd_state_r != `RD_DONE);

  // validity: hardware set wins over the clearing read
  // invalid on mid-sequence rewrite
  sticky_flag i_validity (
    .sys_clk(sys_clk), // system clock
    .rst_n(rst_n), // reset
    .set(latch_now & seq_open), // rewrite mid-sequence
    .clear(rd_validity), // clearing read
    .flag_r(read_invalid_status_r) // invalid data mark
  );

  // interrupt flag: set at every end whatever the mask
  // set always, clear on read
  sticky_flag i_done_flag (
    .sys_clk(sys_clk), // system clock
    .rst_n(rst_n), // reset
    .set(latch_now), // end of reverse integration
    .clear(rd_irq_flag), // clearing read
    .flag_r(conversion_done_flag_r) // interrupt flag
  );

  assign conv_irq = conversion_done_flag_r & conversion_irq_mask_r;

  // read mux, zero outside the mapped page
  always @* begin
    rd_nib = `NIB_ZERO;
    case (idx)
      // interrupt registers
      `IDX_IRQ_FLAG: rd_nib = rb_irq_flag;
      `IDX_IRQ_MASK: rd_nib = rb_irq_mask;
      // converter controls
      `IDX_REF_GND: rd_nib = rb_ref_gnd;
      `IDX_RES_SEL: rd_nib = rb_res_sel;
      `IDX_MEAS_TYPE: rd_nib = rb_meas_type;
      `IDX_IN_EN_LO: rd_nib = rb_in_en_lo;
      `IDX_RUN_IN4: rd_nib = rb_run_in4;
      // result and status
      `IDX_RES_N0: rd_nib = rb_res_n0;
      `IDX_RES_N1: rd_nib = rb_res_n1;
      `IDX_RES_N2: rd_nib = rb_res_n2;
      `IDX_RES_TOP: rd_nib = rb_res_top;
      `IDX_VALIDITY: rd_nib = rb_validity;
      default: rd_nib = `NIB_ZERO;
    endcase
    if (!hit_hi) begin
      rd_nib = `NIB_ZERO;
    end
  end

  // read data held until the next read, so a slow master still sees it
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h00000000;
    end else if (rd) begin
      avs_readdata <= {28'h0000000, rd_nib};
    end
  end

endmodule

// one status bit that hardware sets and a read clears
// a set in the same cycle as the clearing read wins, so no event is lost
// used for the interrupt flag and for the validity bit
module sticky_flag (
  input wire sys_clk, // system clock
  input wire rst_n, // asynchronous reset, active low
  input wire set, // hardware event
  input wire clear, // clearing read taken this cycle
  output reg flag_r // flag state
);

  // set has priority over clear
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= 1'b0;
    end else if (set) begin
      flag_r <= 1'b1;
    end else if (clear) begin
      flag_r <= 1'b0;
    end
  end

endmodule

//--- tb/adc_front.sv
// analog front end stand-in: reports each end of reverse integration
// assumes the bench commands when a conversion ends and with what result
`timescale 1ns/100ps
module adc_front (
  input wire sys_clk, // system clock
  input wire rst_n, // reset, active low
  input wire fire, // end of integration now
  input wire [13:0] val, // polarity and count to report
  output logic conv_done, // end of reverse integration pulse
  output logic conv_positive, // polarity with the pulse
  output logic [12:0] conv_count // count with the pulse
);
  // one pulse per end
  // count and sign flip every cycle outside the pulse so a sample one cycle late never matches
  always @(posedge sys_clk or negedge rst_n)
    if (!rst_n) {conv_done, conv_positive, conv_count} <= 15'h0;
    else begin
      conv_done <= fire;
      {conv_positive, conv_count} <= fire ? val : ~{conv_positive, conv_count};
    end
endmodule

//--- tb/adc_ctrl_properties.sv
// port checker for the adc control block
// assumes word-index addressing and exactly one wait cycle per access
`timescale 1ns/100ps
module adc_ctrl_properties #(parameter COUNT_W = 13) (
  input wire sys_clk, rst_n, avs_read, avs_write, avs_waitrequest,
  input wire [9:0] avs_address,
  input wire [31:0] avs_writedata, avs_readdata,
  input wire [3:0] avs_byteenable, meas_type,
  input wire [1:0] mid_potential_sel, resolution_sel,
  input wire reference_gen_enable, reference_trim_enable, converter_run,
  input wire conv_restart, conv_irq, conv_done, conv_positive,
  input wire [4:0] analog_in_enable,
  input wire [COUNT_W-1:0] conv_count
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // write taken in its first cycle
  sequence s_wr(logic [9:0] a);
    avs_write && avs_waitrequest && avs_byteenable[0] && avs_address == a;
  endsequence
  property p_cfg;
    s_wr(10'h0F0) |=> {mid_potential_sel, reference_trim_enable, reference_gen_enable}
      == $past(avs_writedata[3:0]);
  endproperty
  a_cfg: assert property (p_cfg) else $error("ref cfg");
  property p_res;
    s_wr(10'h0F3) |=> resolution_sel == $past(avs_writedata[1:0]);
  endproperty
  a_res: assert property (p_res) else $error("resolution");
  property p_type;
    s_wr(10'h0F4) |=> meas_type == $past(avs_writedata[3:0]);
  endproperty
  a_type: assert property (p_type) else $error("type");
  property p_inen;
    s_wr(10'h0F5) |=> analog_in_enable[3:0] == $past(avs_writedata[3:0]);
  endproperty
  a_inen: assert property (p_inen) else $error("inputs");
  property p_start;
    s_wr(10'h0F6) ##0 avs_writedata[3] |=> converter_run ##[0:1] conv_restart;
  endproperty
  a_start: assert property (p_start) else $error("start");
  property p_stop;
    s_wr(10'h0F6) ##0 !avs_writedata[3] |=> !converter_run && !conv_restart;
  endproperty
  a_stop: assert property (p_stop) else $error("stop");
  property p_pulse;
    conv_restart |-> converter_run ##1 !conv_restart;
  endproperty
  a_pulse: assert property (p_pulse) else $error("restart");
  property p_rd_hi;
    avs_read && !avs_waitrequest |-> avs_readdata[31:4] == 28'h0;
  endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("upper bits");
  property p_one_wait;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("wait");
endmodule

//--- tb/tb.sv
// self-checking bench for the adc control block
// assumes word-index addressing; the front end model reports conversions
`timescale 1ns/100ps
module tb;
  logic sys_clk = 0, rst_n = 0, avs_read = 0, avs_write = 0, fire = 0;
  logic [9:0] avs_address = 0;
  logic [31:0] avs_writedata = 0, avs_readdata, rd, seed = 39;
  logic [3:0] avs_byteenable = 4'hF, meas_type;
  logic [13:0] val = 0;
  logic avs_waitrequest, conv_done, conv_positive, reference_gen_enable;
  logic reference_trim_enable, converter_run, conv_restart, conv_irq;
  logic [12:0] conv_count;
  logic [1:0] mid_potential_sel, resolution_sel;
  logic [4:0] analog_in_enable;
  // only the nine legal type and input patterns
  logic [8:0] legal [9] = '{9'h001, 9'h002, 9'h004, 9'h008, 9'h010, 9'h023, 9'h04C,
    9'h094, 9'h118};
  int miscompares = 0, checks = 0, i;
  adc_ctrl i_dut (.*);
  adc_front i_front (.*);
  always #4 sys_clk = ~sys_clk;
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task chk(input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %0t got %h want %h", $time, s, e);
    end
  endtask
  // one bus access held until waitrequest drops
  task acc(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    // answer taken at the rising edge where waitrequest is sampled low
    @(posedge sys_clk iff !avs_waitrequest);
    rd = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
  endtask
  task rchk(input logic [9:0] a, input logic [31:0] e);
    acc(0, a, 0);
    chk(rd, e);
  endtask
  task pulse(input logic [13:0] v);
    @(posedge sys_clk);
    fire <= 1;
    val <= v;
    @(posedge sys_clk);
    fire <= 0;
    repeat (2) @(posedge sys_clk);
  endtask
  task final_report;
    if (miscompares == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge sys_clk);
    miscompares++;
    final_report;
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1;
    for (i = 'hF0; i <= 'hFB; i++) rchk(i[9:0], 0);
    rchk(10'h0C4, 0);
    rchk(10'h0C8, 0);
    // random references with every legal input combination
    for (i = 0; i < 9; i++) begin
      seed = xs(seed);
      acc(1, 10'h0F0, seed);
      acc(1, 10'h0F3, seed >> 4);
      acc(1, 10'h0F5, legal[i][3:0]);
      acc(1, 10'h0F4, legal[i][8:5]);
      acc(1, 10'h0F6, legal[i][4]);
      chk({mid_potential_sel, reference_trim_enable, reference_gen_enable}, seed[3:0]);
      rchk(10'h0F0, seed[3:0]);
      rchk(10'h0F3, seed[5:4]);
      chk({meas_type, analog_in_enable}, legal[i]);
      rchk(10'h0F6, legal[i][4]);
    end
    acc(1, 10'h0F6, 8);
    rchk(10'h0F6, 8);
    acc(1, 10'h0C8, 4);
    rchk(10'h0C8, 4);
    pulse(seed[13:0]);
    chk(conv_irq, 1);
    rchk(10'h0C4, 1);
    rchk(10'h0C4, 0);
    chk(conv_irq, 0);
    acc(1, 10'h0F7, 32'hF);
    rchk(10'h0F7, val[3:0]);
    rchk(10'h0F8, val[7:4]);
    rchk(10'h0F9, val[11:8]);
    rchk(10'h0FA, val[13:12]);
    rchk(10'h0FB, 0);
    // new result lands in mid-read after a restart
    rchk(10'h0F7, val[3:0]);
    acc(1, 10'h0F6, 8);
    pulse(~val);
    rchk(10'h0F8, val[7:4]);
    rchk(10'h0F9, val[11:8]);
    rchk(10'h0FA, val[13:12]);
    rchk(10'h0FB, 1);
    rchk(10'h0FB, 0);
    acc(1, 10'h0C8, 0);
    pulse(seed[27:14]);
    chk(conv_irq, 0);
    rchk(10'h0C4, 1);
    acc(1, 10'h0F6, 0);
    chk(converter_run, 0);
    pulse(seed[13:0]);
    rchk(10'h0C4, 0);
    acc(1, 10'h0F0, 0);
    rchk(10'h0F0, 0);
    final_report;
  end
endmodule
bind adc_ctrl adc_ctrl_properties #(.COUNT_W(COUNT_W)) i_chk (.*);
